// ### common/pgmb_defs.vh
// register offsets, field positions and reset values of the measurement buffer
// assumes a 32-bit AXI4-Lite slave, byte addresses, one aligned word per register
// Functional notes
// (R01) gate start is a percent of pulse duration from rising to falling midpoint
// (R02) gate start accepts 0.00 to 40.00 percent, used in pulse mode only
// (R03) automatic pulse results average only samples between gate start and end
// (R04) level-unit selector makes level percentages refer to volts or watts
// (R05) power percent is square of voltage percent, 10% volts is 1% power
// (R06) per-channel sensor type reads as none, cw, voltage probe or peak, always
// (R07) buffer holds up to 1M readings at the programmed acquisition rate
// (R08) no readings are captured while statistical mode is active
// (R09) fixed mode fills from start to programmed count, stops, flags complete
// (R10) a filled fixed buffer keeps its contents while measuring goes on
// (R11) circular mode ignores size, is never full, wraps and overwrites oldest
// (R12) each stored reading is readable at once, before buffering finishes
// (R13) host reads position, reads from start and count, or all unread points
// (R14) circular readout runs from oldest unread to newest, like a fifo
// (R15) modulated entries equal the filtered average, minimum or maximum reading
// (R16) pulse entries are the marker-interval result of one averaged sweep
// (R17) host should set trace averaging to one and timebase 1us/div or slower
// (R18) rearm gap between buffered sweeps is lengthened by holdoff and delays
// (R19) buffered sweep rate falls from about 625Hz to 20Hz as timebase grows
// (R20) size zero disables buffering, size minus one selects circular mode
// (R21) writing the size resets the write position of both channels
// (R22) write index steps per stored reading, read index per delivered reading
// (R23) circular overwrite of unread data moves oldest-unread to oldest held
`ifndef PGMB_DEFS_VH
`define PGMB_DEFS_VH
`define PGMB_OFF_CTRL 6'h00
`define PGMB_OFF_SIZE 6'h04
`define PGMB_OFF_STATUS 6'h08
`define PGMB_OFF_WRPOS 6'h0c
`define PGMB_OFF_RDPOS 6'h10
`define PGMB_OFF_RDCNT 6'h14
`define PGMB_OFF_RDALL 6'h18
`define PGMB_OFF_DATA 6'h1c
`define PGMB_OFF_GSTART 6'h20
`define PGMB_OFF_GEND 6'h24
`define PGMB_OFF_MESIAL 6'h28
`define PGMB_OFF_MESPWR 6'h2c
`define PGMB_OFF_HOLDOFF 6'h30
`define PGMB_OFF_GSUM 6'h34
`define PGMB_OFF_GCNT 6'h38
`define PGMB_OFF_UNREAD 6'h3c
`define PGMB_MODE_MOD 2'h0
`define PGMB_MODE_PULSE 2'h1
`define PGMB_MODE_STAT 2'h2
`define PGMB_CTRL_UNIT 2
`define PGMB_CTRL_RDCH 3
`define PGMB_SIZE_OFF 32'h00000000
`define PGMB_SIZE_CIRC 32'hffffffff
`define PGMB_GSTART_MAX 32'h00000fa0
`define PGMB_GEND_MIN 32'h00001770
`define PGMB_GEND_MAX 32'h00002710
`define PGMB_PCT_SCALE 32'h00002710
`define PGMB_RST_GSTART 32'h000003e8
`define PGMB_RST_GEND 32'h00002328
`define PGMB_RST_MESIAL 32'h00001388
`define PGMB_RESP_OKAY 2'h0
`define PGMB_RESP_SLVERR 2'h2
`endif

// ### core/pgmb_core.v
// measurement buffer, pulse gating and level-unit logic with an axi4-lite slave
// assumes readings, samples and sensor codes arrive synchronous to aclk
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`include "pgmb_defs.vh"
module pgmb_core #(
	parameter AW = 20,
	parameter DW = 32
) (
	input wire aclk,
	input wire aresetn,
	input wire [5:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [5:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire reading_valid,
	input wire [DW-1:0] reading_ch0,
	input wire [DW-1:0] reading_ch1,
	input wire sample_valid,
	input wire [13:0] sample_phase,
	input wire [DW-1:0] sample_ch0,
	input wire [DW-1:0] sample_ch1,
	input wire sweep_end,
	input wire [1:0] sensor_type_ch0,
	input wire [1:0] sensor_type_ch1,
	output reg measurement_complete,
	output reg [1:0] op_mode,
	output reg level_unit_watts
);
	localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
	reg [31:0] ctrl;
	reg [31:0] buf_size;
	reg [31:0] gate_start;
	reg [31:0] gate_end;
	reg [31:0] mesial;
	reg [31:0] holdoff;
	reg [31:0] hold_cnt;
	reg [AW-1:0] wr_ptr;
	reg [AW:0] fill;
	reg done;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] unread;
	reg [AW:0] remain;
	reg [5:0] aw_addr;
	reg aw_have;
	reg [31:0] w_data;
	reg w_have;
	reg [5:0] ar_addr;
	reg rd_p1;
	reg rd_p2;
	wire [DW-1:0] mem_q [0:1];
	wire [47:0] g_sum [0:1];
	wire [31:0] g_cnt [0:1];
	wire [2*DW-1:0] rd_bus = {reading_ch1, reading_ch0};
	wire [2*DW-1:0] smp_bus = {sample_ch1, sample_ch0};
	wire circ = (buf_size == `PGMB_SIZE_CIRC);
	wire enabled = (buf_size != `PGMB_SIZE_OFF);
	wire is_stat = (ctrl[1:0] == `PGMB_MODE_STAT);
	wire is_pulse = (ctrl[1:0] == `PGMB_MODE_PULSE);
	wire fixed_full = !circ && ({{(31-AW){1'b0}}, fill} >= buf_size);
	// statistical mode and disabled buffer drop readings; holdoff spaces sweeps
	wire take = reading_valid && enabled && !is_stat && !fixed_full && hold_cnt == 32'h0; // (R08) (R20) (R10)
	wire wr_fire = aw_have && w_have && !s_axi_bvalid;
	wire rd_ch = ctrl[`PGMB_CTRL_RDCH];
	wire pop = rd_p2 && ar_addr == `PGMB_OFF_DATA && remain != {(AW+1){1'b0}};
	wire [63:0] mes_sq = mesial * mesial;
	wire [63:0] mes_div = mes_sq / {32'h0, `PGMB_PCT_SCALE};
	// the quotient never exceeds the scale, so the upper half is always zero
	wire [31:0] mes_pwr = level_unit_watts ? mesial : mes_div[31:0]; // (R05)
	wire [AW:0] wval = w_data[AW:0];

	// both channels share one write index so their buffers stay aligned
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
			reg [DW-1:0] mem [0:(1<<AW)-1]; // (R07)
			reg [DW-1:0] q;
			reg [47:0] acc;
			reg [31:0] cnt;
			reg [47:0] sum_out;
			reg [31:0] cnt_out;
			wire in_gate = sample_phase >= gate_start[13:0] && sample_phase <= gate_end[13:0]; // (R01)
			always @(posedge aclk) begin
				if (take) begin
					mem[wr_ptr] <= rd_bus[ch*DW +: DW]; // (R15) (R16)
				end
				q <= mem[rd_ptr]; // (R12)
			end
			always @(posedge aclk) begin
				if (!aresetn) begin
					acc <= 48'h0;
					cnt <= 32'h0;
					sum_out <= 48'h0;
					cnt_out <= 32'h0;
				end else if (sweep_end) begin
					sum_out <= acc;
					cnt_out <= cnt;
					acc <= 48'h0;
					cnt <= 32'h0;
				end else if (sample_valid && is_pulse && in_gate) begin // (R02) (R03)
					acc <= acc + {16'h0, smp_bus[ch*DW +: DW]};
					cnt <= cnt + 32'h1;
				end
			end
			assign mem_q[ch] = q;
			assign g_sum[ch] = sum_out;
			assign g_cnt[ch] = cnt_out;
		end
	endgenerate

	// buffer control and register writes
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= 32'h0;
			buf_size <= `PGMB_SIZE_OFF;
			gate_start <= `PGMB_RST_GSTART;
			gate_end <= `PGMB_RST_GEND;
			mesial <= `PGMB_RST_MESIAL;
			holdoff <= 32'h0;
			hold_cnt <= 32'h0;
			wr_ptr <= {AW{1'b0}};
			fill <= {(AW+1){1'b0}};
			done <= 1'b0;
			rd_ptr <= {AW{1'b0}};
			unread <= {(AW+1){1'b0}};
			remain <= {(AW+1){1'b0}};
		end else if (wr_fire && aw_addr == `PGMB_OFF_SIZE) begin
			buf_size <= w_data; // (R20)
			wr_ptr <= {AW{1'b0}}; // (R21)
			fill <= {(AW+1){1'b0}};
			done <= 1'b0;
			rd_ptr <= {AW{1'b0}};
			unread <= {(AW+1){1'b0}};
			remain <= {(AW+1){1'b0}};
			hold_cnt <= 32'h0;
		end else begin
			if (wr_fire) begin
				case (aw_addr)
					`PGMB_OFF_CTRL: ctrl <= {28'h0, w_data[3:0]}; // (R04)
					`PGMB_OFF_GSTART: gate_start <= (w_data > `PGMB_GSTART_MAX) ? `PGMB_GSTART_MAX : w_data; // (R02)
					`PGMB_OFF_GEND: gate_end <= (w_data < `PGMB_GEND_MIN) ? `PGMB_GEND_MIN :
						(w_data > `PGMB_GEND_MAX) ? `PGMB_GEND_MAX : w_data;
					`PGMB_OFF_MESIAL: mesial <= (w_data > `PGMB_PCT_SCALE) ? `PGMB_PCT_SCALE : w_data;
					`PGMB_OFF_HOLDOFF: holdoff <= w_data;
					default: begin
					end
				endcase
			end
			// rearm gap: a buffered sweep blocks the next for holdoff cycles
			if (take && is_pulse) begin
				hold_cnt <= holdoff; // (R18) (R19)
			end else if (hold_cnt != 32'h0) begin
				hold_cnt <= hold_cnt - 32'h1;
			end
			if (take) begin
				wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1}; // (R22) (R11)
				if (fill != DEPTH) begin
					fill <= fill + {{AW{1'b0}}, 1'b1};
				end
				if (!circ && ({{(31-AW){1'b0}}, fill} + 32'h1 == buf_size)) begin
					done <= 1'b1; // (R09)
				end
			end
			if (wr_fire && aw_addr == `PGMB_OFF_RDPOS) begin
				rd_ptr <= w_data[AW-1:0]; // (R13)
				unread <= (wval < fill) ? fill - wval : {(AW+1){1'b0}};
			end else if (take && pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1}; // (R22)
			end else if (take) begin
				if (unread == DEPTH) begin
					rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1}; // (R23) (R14)
				end else begin
					unread <= unread + {{AW{1'b0}}, 1'b1};
				end
			end else if (pop) begin
				rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1}; // (R14)
				if (unread != {(AW+1){1'b0}}) begin
					unread <= unread - {{AW{1'b0}}, 1'b1};
				end
			end
			if (wr_fire && aw_addr == `PGMB_OFF_RDCNT) begin
				remain <= wval; // (R13)
			end else if (wr_fire && aw_addr == `PGMB_OFF_RDALL) begin
				remain <= unread; // (R13)
			end else if (pop) begin
				remain <= remain - {{AW{1'b0}}, 1'b1};
			end
		end
	end

	// write channel: address and data taken in either order, response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= 6'h0;
			aw_have <= 1'b0;
			w_data <= 32'h0;
			w_have <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PGMB_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= {s_axi_awaddr[5:2], 2'b00};
				aw_have <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				// partial strobes are treated as full words; registers are word-wide
				w_data <= s_axi_wdata;
				w_have <= 1'b1;
			end
			if (wr_fire) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == `PGMB_OFF_STATUS || aw_addr == `PGMB_OFF_WRPOS ||
					aw_addr == `PGMB_OFF_DATA || aw_addr == `PGMB_OFF_MESPWR ||
					aw_addr == `PGMB_OFF_GSUM || aw_addr == `PGMB_OFF_GCNT ||
					aw_addr == `PGMB_OFF_UNREAD) ? `PGMB_RESP_SLVERR : `PGMB_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel: two cycles of latency let the buffer memory settle
	always @(posedge aclk) begin
		if (!aresetn) begin
			ar_addr <= 6'h0;
			rd_p1 <= 1'b0;
			rd_p2 <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `PGMB_RESP_OKAY;
		end else begin
			s_axi_arready <= !rd_p1 && !rd_p2 && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			rd_p2 <= rd_p1;
			rd_p1 <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				ar_addr <= {s_axi_araddr[5:2], 2'b00};
				rd_p1 <= 1'b1;
			end
			if (rd_p2) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `PGMB_RESP_OKAY;
				case (ar_addr)
					`PGMB_OFF_CTRL: s_axi_rdata <= ctrl;
					`PGMB_OFF_SIZE: s_axi_rdata <= buf_size;
					`PGMB_OFF_STATUS: s_axi_rdata <= {20'h0, sensor_type_ch1, sensor_type_ch0,
						4'h0, (circ && unread == DEPTH), enabled, circ, done}; // (R06) (R11)
					`PGMB_OFF_WRPOS: s_axi_rdata <= {{(31-AW){1'b0}}, fill}; // (R13)
					`PGMB_OFF_RDPOS: s_axi_rdata <= {{(32-AW){1'b0}}, rd_ptr};
					`PGMB_OFF_RDCNT: s_axi_rdata <= {{(31-AW){1'b0}}, remain};
					`PGMB_OFF_UNREAD: s_axi_rdata <= {{(31-AW){1'b0}}, unread};
					`PGMB_OFF_DATA: s_axi_rdata <= mem_q[rd_ch]; // (R12)
					`PGMB_OFF_GSTART: s_axi_rdata <= gate_start;
					`PGMB_OFF_GEND: s_axi_rdata <= gate_end;
					`PGMB_OFF_MESIAL: s_axi_rdata <= mesial;
					`PGMB_OFF_MESPWR: s_axi_rdata <= mes_pwr; // (R05)
					`PGMB_OFF_HOLDOFF: s_axi_rdata <= holdoff;
					`PGMB_OFF_GSUM: s_axi_rdata <= g_sum[rd_ch][31:0]; // (R03)
					`PGMB_OFF_GCNT: s_axi_rdata <= g_cnt[rd_ch];
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `PGMB_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// plain outputs registered from the control state
	always @(posedge aclk) begin
		if (!aresetn) begin
			measurement_complete <= 1'b0;
			op_mode <= `PGMB_MODE_MOD;
			level_unit_watts <= 1'b0;
		end else begin
			measurement_complete <= done; // (R09)
			op_mode <= ctrl[1:0];
			level_unit_watts <= ctrl[`PGMB_CTRL_UNIT]; // (R04)
		end
	end
endmodule

// ### verif/pgmb_core_props.sv
// checker for the buffer core: bus answers, refusals and status outputs
// assumes one clock domain and a bind onto pgmb_core
module pgmb_core_props (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire reading_valid,
	input wire measurement_complete,
	input wire [1:0] op_mode,
	input wire level_unit_watts
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// cycles since the last write data handshake, saturating so it never wraps
	reg [2:0] since_w;
	always @(posedge aclk) begin
		if (!aresetn || (s_axi_wvalid && s_axi_wready))
			since_w <= !aresetn ? 3'h7 : 3'h0;
		else if (since_w != 3'h7)
			since_w <= since_w + 3'h1;
	end
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:4] s_axi_rvalid)
		else $error("read answer late");
	chk_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	chk_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	chk_data_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	chk_done_cause: assert property ($rose(measurement_complete) |-> ($past(reading_valid, 1) || $past(reading_valid, 2)) && $past(op_mode, 1) != 2'h2)
		else $error("complete without a stored reading");
	chk_done_clear: assert property ($fell(measurement_complete) |-> since_w < 3'h5)
		else $error("complete cleared without a size write");
	chk_mode_cause: assert property (!$stable({op_mode, level_unit_watts}) |-> since_w < 3'h5)
		else $error("mode or unit changed without a write");
	cover property ($rose(measurement_complete));
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
	cover property (s_axi_rvalid && s_axi_rready && op_mode == 2'h1);
endmodule
bind pgmb_core pgmb_core_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .reading_valid, .measurement_complete,
	.op_mode, .level_unit_watts);

// ### verif/pgmb_host_model.sv
// host model: axi4-lite master standing in for the remote reader
// assumes the slave answers on its own; only the bench watchdog ends a wait
module pgmb_host_model (
	input wire aclk,
	output logic [5:0] s_axi_awaddr = 6'h00,
	output logic s_axi_awvalid = 1'b0,
	input wire s_axi_awready,
	output logic [31:0] s_axi_wdata = 32'h0,
	output logic s_axi_wvalid = 1'b0,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output logic s_axi_bready = 1'b0,
	output logic [5:0] s_axi_araddr = 6'h00,
	output logic s_axi_arvalid = 1'b0,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	output logic s_axi_rready = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// one access at a time; callers keep settings within the accepted ranges
	task wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		bit at;
		bit dt;
		@(posedge aclk);
		at = 0;
		dt = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(at && dt)) begin
			@(posedge aclk);
			at = at || s_axi_awready;
			dt = dt || s_axi_wready;
			s_axi_awvalid <= !at;
			s_axi_wvalid <= !dt;
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		while (s_axi_arready !== 1'b1) @(posedge aclk);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ### verif/pulse_gate_measurement_buffer_tb.sv
// bench for pgmb_core: host bus calls, reading and sample pulses
// assumes the host model and the checker are compiled first
`include "pgmb_defs.vh"
module pulse_gate_measurement_buffer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int AW = 4;
	logic aclk = 0;
	logic aresetn = 0;
	wire [5:0] s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [1:0] s_axi_bresp, s_axi_rresp, op_mode;
	wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	wire measurement_complete, level_unit_watts;
	logic reading_valid = 0, sample_valid = 0, sweep_end = 0;
	logic [31:0] reading_ch0 = 0, sample_ch0 = 0, got;
	logic [13:0] sample_phase = 0;
	logic [1:0] sensor_type_ch0 = 0, sensor_type_ch1 = 0, resp;
	int mismatches = 0, samples_checked = 0;
	int ph[7] = '{0, 999, 1000, 5000, 9000, 9001, 10000};
	pgmb_core #(.AW(AW)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reading_valid, .reading_ch0,
		.reading_ch1(~reading_ch0), .sample_valid, .sample_phase, .sample_ch0,
		.sample_ch1(sample_ch0), .sweep_end, .sensor_type_ch0, .sensor_type_ch1,
		.measurement_complete, .op_mode, .level_unit_watts);
	pgmb_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
	initial forever #2 aclk = ~aclk;
	task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task rdc(input logic [5:0] a, input logic [31:0] exp, input string what);
		host.rd(a, got);
		check(what, exp, got);
	endtask
	task wr(input logic [5:0] a, input logic [31:0] d);
		host.wr(a, d, resp);
		check("bresp", {30'h0, `PGMB_RESP_OKAY}, {30'h0, resp});
	endtask
	// a second edge before the next pulse, so valid is never set twice in one step
	task push(input logic [31:0] v);
		@(posedge aclk);
		reading_valid <= 1'b1;
		reading_ch0 <= v;
		@(posedge aclk);
		reading_valid <= 1'b0;
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		conclude;
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rdc(`PGMB_OFF_GSTART, 32'h3e8, "gstart");
		rdc(`PGMB_OFF_SIZE, 32'h0, "size");
		check("rresp", {30'h0, `PGMB_RESP_OKAY}, {30'h0, s_axi_rresp});
		rdc(`PGMB_OFF_GEND, 32'h2328, "gend");
		rdc(`PGMB_OFF_RDALL, 32'h0, "rdall read");
		check("rresp err", {30'h0, `PGMB_RESP_SLVERR}, {30'h0, s_axi_rresp});
		wr(`PGMB_OFF_GSTART, 32'hfa0);
		rdc(`PGMB_OFF_GSTART, 32'hfa0, "gstart max");
		wr(`PGMB_OFF_MESIAL, 32'h2328);
		rdc(`PGMB_OFF_MESPWR, 32'h1fa4, "mespwr volts");
		wr(`PGMB_OFF_CTRL, 32'h6);
		rdc(`PGMB_OFF_MESPWR, 32'h2328, "mespwr watts");
		check("unit", 32'h1, {31'h0, level_unit_watts});
		check("mode", 32'h2, {30'h0, op_mode});
		for (int i = 0; i < 4; i++) begin
			sensor_type_ch0 <= 2'(i);
			sensor_type_ch1 <= 2'(3 - i);
			host.rd(`PGMB_OFF_STATUS, got);
			check("sensor", {20'h0, 2'(3 - i), 2'(i), 8'h0}, got & 32'hf00);
		end
		wr(`PGMB_OFF_SIZE, 32'h4);
		push(32'h1);
		rdc(`PGMB_OFF_WRPOS, 32'h0, "stat wrpos");
		wr(`PGMB_OFF_CTRL, 32'h0);
		wr(`PGMB_OFF_SIZE, 32'h3);
		push(32'ha);
		wr(`PGMB_OFF_RDALL, 32'h0);
		rdc(`PGMB_OFF_DATA, 32'ha, "early data");
		for (int i = 1; i < 5; i++) push(32'ha + i);
		repeat (3) @(posedge aclk);
		check("complete", 32'h1, {31'h0, measurement_complete});
		rdc(`PGMB_OFF_WRPOS, 32'h3, "fixed wrpos");
		wr(`PGMB_OFF_RDPOS, 32'h1);
		wr(`PGMB_OFF_RDCNT, 32'h2);
		rdc(`PGMB_OFF_DATA, 32'hb, "fixed data");
		rdc(`PGMB_OFF_DATA, 32'hc, "fixed data");
		wr(`PGMB_OFF_CTRL, 32'h8);
		wr(`PGMB_OFF_RDPOS, 32'h0);
		wr(`PGMB_OFF_RDCNT, 32'h1);
		rdc(`PGMB_OFF_DATA, ~32'ha, "ch1 data");
		wr(`PGMB_OFF_CTRL, 32'h0);
		wr(`PGMB_OFF_SIZE, 32'h3);
		rdc(`PGMB_OFF_WRPOS, 32'h0, "size reset");
		check("complete clear", 32'h0, {31'h0, measurement_complete});
		wr(`PGMB_OFF_SIZE, `PGMB_SIZE_CIRC);
		for (int i = 0; i < 20; i++) push(32'h64 + i);
		rdc(`PGMB_OFF_WRPOS, 32'h10, "circ wrpos");
		rdc(`PGMB_OFF_UNREAD, 32'h10, "circ unread");
		host.rd(`PGMB_OFF_STATUS, got);
		check("never full", 32'h2, got & 32'h3);
		wr(`PGMB_OFF_RDALL, 32'h0);
		for (int i = 4; i < 20; i++) rdc(`PGMB_OFF_DATA, 32'h64 + i, "fifo data");
		rdc(`PGMB_OFF_UNREAD, 32'h0, "drained");
		host.wr(`PGMB_OFF_WRPOS, 32'h0, resp);
		check("ro bresp", {30'h0, `PGMB_RESP_SLVERR}, {30'h0, resp});
		wr(`PGMB_OFF_CTRL, 32'h1);
		wr(`PGMB_OFF_HOLDOFF, 32'h5);
		wr(`PGMB_OFF_SIZE, `PGMB_SIZE_CIRC);
		push(32'h1);
		push(32'h2);
		repeat (10) @(posedge aclk);
		push(32'h3);
		rdc(`PGMB_OFF_WRPOS, 32'h2, "holdoff");
		wr(`PGMB_OFF_GSTART, 32'h3e8);
		// one sweep of seven samples across both gate edges, then gate count and sum are read back
		foreach (ph[i]) begin
			@(posedge aclk);
			sample_valid <= 1'b1;
			sample_phase <= 14'(ph[i]);
			sample_ch0 <= 32'(ph[i]);
			@(posedge aclk);
			sample_valid <= 1'b0;
		end
		sweep_end <= 1'b1;
		@(posedge aclk);
		sweep_end <= 1'b0;
		rdc(`PGMB_OFF_GCNT, 32'h3, "gate count");
		rdc(`PGMB_OFF_GSUM, 32'h3a98, "gate sum");
		conclude;
	end
endmodule
